// ### slbc_top.sv
// Purpose: back-channel control, self test and status of the hub side
// Assumes: bus already decoded into a register port
// Notes:   reads return one cycle after the read strobe
// Contract
// R01: five rate codes, three reserved
// R02: strap sets rate on power-down release
// R03: bit 7 forwards all transactions
// R04: bit 6 forwards matched transactions
// R05: bit 5 acks all writes
// R06: bit 4 keeps back channel on
// R07: keep-on written only locally
// R08: bit 3 enables CRC generator
// R09: host sets auto-ack before rate change
// R10: test request sent to far side
// R11: far side sends pattern at speed
// R12: per-port pattern error count
// R13: far side counts CRC failures
// R14: self test clock source select
// R15: logic, full and ROM reload resets
// R16: lock needs PLL and valid data
// R17: far status bit layout
// R18: paged writes only to enabled ports
// R19: device and alias addresses held
// R20: host prefers register-keeping reset
// R21: enable bit starts and stops test
// R22: one-shot or continuous error inject
// R23: error counter saturates
// R24: reserved rate codes keep old rate
module slbc_top
  import slbc_pkg::*;
#(
  parameter int NP = 2,  // receive ports
  parameter int CW = 8   // error counter width
) (
  input  wire logic          i_mclk,          // clock
  input  wire logic          i_rst_b,         // async reset, low

  input  wire logic          i_reg_wr,        // write strobe
  input  wire logic          i_reg_rd,        // read strobe
  input  wire logic [7:0]    i_reg_addr,      // offset
  input  wire logic [7:0]    i_reg_wdata,     // write data
  input  wire logic          i_reg_from_link, // remote write
  output      logic [7:0]    o_reg_rdata,     // read data

  input  wire logic          i_power_down_release, // pin
  input  wire logic [2:0]    i_strap_rate,    // strap pins
  input  wire logic          i_pll_locked,    // PLL lock pin
  input  wire logic          i_rx_valid,      // data valid pin
  input  wire logic          i_refclk_valid,  // refclk pin

  input  wire logic          i_bus_txn,       // bus transaction
  input  wire logic          i_bus_wr,        // it is a write
  input  wire logic          i_addr_match,    // decode hit
  input  wire logic          i_remote_ack,    // far ack
  output      logic          o_forward,       // pass on
  output      logic          o_write_ack,     // ack write

  output      logic          o_bc_enable,     // channel on
  output      logic [2:0]    o_bc_rate,       // rate code
  output      logic          o_bc_crc_en,     // CRC on
  output      logic          o_selftest_req,  // test request
  output      logic          o_selftest_osc,  // internal osc
  output      logic          o_soft_reset,    // logic reset
  output      logic          o_rom_reload,    // reload pulse
  output      logic [NP-1:0] o_err_inject,    // error force
  input  wire logic [NP-1:0] i_rx_bit,        // pattern bits
  input  wire logic [NP-1:0] i_rx_bit_valid,  // bit qualifiers
  output      logic          o_lock           // lock status
);
  localparam int PW = (NP > 1) ? $clog2(NP) : 1;

  typedef struct packed {
    logic [7:0]    dev_addr;
    logic [7:0]    alias_addr;
    logic [7:0]    port_sel;
    logic [7:0]    bc_cfg;
    logic [2:0]    rate_eff;

    logic [7:0]    st_cfg;
    logic [NP-1:0] dbg_cont;
    logic [NP-1:0] inj_one;

    logic          soft_rst;
    logic          rom_reload;
    logic          init_done;
    logic          pdr_prev;
    logic          st_prev;

    logic [7:0]    rdata;
  } slbc_top_st_t;

  localparam slbc_top_st_t ST_RST = '{
    dev_addr:   DEV_ADDR_RST,
    alias_addr: ALIAS_RST,
    port_sel:   PORT_SEL_RST,
    bc_cfg:     BC_CFG_RST,
    rate_eff:   RATE_RST,
    st_cfg:     ST_CFG_RST,
    default:    '0
  };

  slbc_top_st_t  st;
  slbc_top_st_t  next_st;

  logic [6:0]    pin_sync;
  logic          pdr_s;
  logic [2:0]    strap_s;
  logic          pll_s;
  logic          rxv_s;
  logic          refclk_s;

  logic          lock;
  logic          st_start;
  logic          chk_clear;

  logic [CW-1:0] err_cnt [NP];
  logic [PW-1:0] rd_port;

  logic [7:0]    cnt_byte;
  logic [7:0]    dbg_byte;
  logic [7:0]    sts_byte;

  // every pin level passes two flops before use
  slbc_sync #(
    .W (7)
  ) u_pin_sync (
    .i_mclk  (i_mclk),
    .i_rst_b (i_rst_b),
    .i_d     ({i_power_down_release, i_strap_rate, i_pll_locked,
               i_rx_valid, i_refclk_valid}),
    .o_q     (pin_sync)
  );

  assign pdr_s    = pin_sync[6];
  assign strap_s  = pin_sync[5:3];
  assign pll_s    = pin_sync[2];
  assign rxv_s    = pin_sync[1];
  assign refclk_s = pin_sync[0];

  // lock needs both PLL lock and valid recovered data
  assign lock = pll_s & rxv_s; // [R16]

  // counters restart on test start or logic reset
  assign st_start  = st.st_cfg[ST_EN] & ~st.st_prev; // [R21]
  assign chk_clear = st_start | st.soft_rst;

  // one pattern checker per receive port
  for (genvar p = 0; p < NP; p++) begin : g_port
    slbc_chk_if #(.W (CW)) u_if ();

    assign u_if.run     = st.st_cfg[ST_EN]; // [R12]
    assign u_if.clear   = chk_clear;
    assign u_if.bit_in  = i_rx_bit[p];
    assign u_if.bit_vld = i_rx_bit_valid[p];
    assign err_cnt[p]   = u_if.count;

    slbc_prbs_chk #(
      .W (CW)
    ) u_chk (
      .i_mclk  (i_mclk),
      .i_rst_b (i_rst_b),
      .u_chk   (u_if)
    );
  end

  // the read page is picked by a field of the port select
  assign rd_port = st.port_sel[SEL_RD_PORT +: PW];

  // paged reads; an out-of-range page reads zero
  always_comb begin
    cnt_byte = 8'h00;
    dbg_byte = 8'h00;
    for (int p = 0; p < NP; p++) begin
      if (rd_port == PW'(p)) begin
        cnt_byte = 8'(err_cnt[p]); // [R12]
        dbg_byte[DBG_CONT] = st.dbg_cont[p];
      end
    end
  end

  // status reads 0xCF on a locked, healthy link
  always_comb begin
    sts_byte = 8'h00;
    sts_byte[STS_CKSUM]  = 1'b1;
    sts_byte[STS_INIT]   = st.init_done;
    sts_byte[STS_REFCLK] = refclk_s;
    sts_byte[STS_PASS]   = lock;
    sts_byte[STS_RCLK]   = lock;
    sts_byte[STS_LOCK]   = lock; // [R16]
  end

  // register writes, strap capture and self-clearing pulses
  always_comb begin
    next_st            = st;
    next_st.soft_rst   = 1'b0;
    next_st.rom_reload = 1'b0;
    next_st.inj_one    = '0;
    next_st.pdr_prev   = pdr_s;
    next_st.st_prev    = st.st_cfg[ST_EN];
    next_st.init_done  = 1'b1;

    // strap caught on power-down release
    if (pdr_s && !st.pdr_prev) begin
      next_st.bc_cfg[2:0] = strap_s; // [R02]
      if (strap_s == RATE_2M5 || strap_s[2]) begin
        next_st.rate_eff = strap_s;
      end
    end

    if (i_reg_wr) begin
      case (i_reg_addr)
        ADDR_BUS_DEV: begin
          next_st.dev_addr = i_reg_wdata; // [R19]
        end

        ADDR_ALIAS: begin
          next_st.alias_addr = i_reg_wdata; // [R19]
        end

        ADDR_RST_CTL: begin
          // bits self-clear; reserved bits are dropped
          next_st.soft_rst   = i_reg_wdata[RST_KEEP_REGS]; // [R15]
          next_st.rom_reload = i_reg_wdata[RST_ROM]; // [R15]
          if (i_reg_wdata[RST_ROM]) begin
            next_st.init_done = 1'b0;
          end
        end

        ADDR_PORT_SEL: begin
          next_st.port_sel = i_reg_wdata;
        end

        ADDR_BC_CFG: begin
          next_st.bc_cfg = i_reg_wdata;
          // a far host cannot change the keep-on bit
          if (i_reg_from_link) begin
            next_st.bc_cfg[BC_KEEP_ON] = st.bc_cfg[BC_KEEP_ON]; // [R07]
          end
          // reserved codes read back but do not retune [R24]
          if (i_reg_wdata[2:0] == RATE_2M5 || i_reg_wdata[2]) begin
            next_st.rate_eff = i_reg_wdata[2:0]; // [R01]
          end
        end

        ADDR_ST_CFG: begin
          next_st.st_cfg = i_reg_wdata; // [R21] [R14]
        end

        ADDR_PORT_DBG: begin
          for (int p = 0; p < NP; p++) begin
            // unselected ports keep their value
            if (st.port_sel[p]) begin // [R18]
              next_st.inj_one[p]  = i_reg_wdata[DBG_ONE]; // [R22]
              next_st.dbg_cont[p] = i_reg_wdata[DBG_CONT]; // [R22]
            end
          end
        end

        default: begin
        end
      endcase
      // full reset also returns the register file to its reset values
      if (i_reg_addr == ADDR_RST_CTL && i_reg_wdata[RST_ALL]) begin
        next_st          = ST_RST; // [R15]
        next_st.soft_rst = 1'b1;
        next_st.pdr_prev = pdr_s;
      end
    end

    // read data; unmapped offsets return zero
    if (i_reg_rd) begin
      case (i_reg_addr)
        ADDR_BUS_DEV:    next_st.rdata = st.dev_addr;
        ADDR_RST_CTL:    next_st.rdata = 8'h00;
        ADDR_DES_STS:    next_st.rdata = sts_byte;
        ADDR_PORT_SEL:   next_st.rdata = st.port_sel;
        ADDR_ST_ERR_CNT: next_st.rdata = cnt_byte;
        ADDR_BC_CFG:     next_st.rdata = st.bc_cfg;
        ADDR_ALIAS:      next_st.rdata = st.alias_addr;
        ADDR_ST_CFG:     next_st.rdata = st.st_cfg;
        ADDR_PORT_DBG:   next_st.rdata = dbg_byte;
        default:         next_st.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  // on unless keep-on and both passthroughs are clear
  assign o_bc_enable = st.bc_cfg[BC_KEEP_ON]
                     | st.bc_cfg[BC_PASS_ALL]
                     | st.bc_cfg[BC_PASS_MATCH]; // [R06]

  // forwarding: all transactions, or only decoded ones
  assign o_forward = i_bus_txn & o_bc_enable
                   & (st.bc_cfg[BC_PASS_ALL] // [R03]
                   | (st.bc_cfg[BC_PASS_MATCH] & i_addr_match)); // [R04]

  // auto-ack hides a missing far response, e.g. while retuning
  assign o_write_ack = i_bus_txn & i_bus_wr
                     & (st.bc_cfg[BC_AUTO_ACK] // [R05] [R09]
                     | (lock & i_remote_ack));

  assign o_bc_rate      = st.rate_eff; // [R01] [R24]
  assign o_bc_crc_en    = st.bc_cfg[BC_CRC_EN]; // [R08]

  assign o_selftest_req = st.st_cfg[ST_EN]; // [R10]
  assign o_selftest_osc = st.st_cfg[ST_OSC]; // [R14]

  assign o_soft_reset   = st.soft_rst;
  assign o_rom_reload   = st.rom_reload;

  assign o_err_inject   = st.inj_one | st.dbg_cont; // [R22]

  assign o_reg_rdata    = st.rdata;
  assign o_lock         = lock;
endmodule : slbc_top

// ### slbc_pkg.sv
// Purpose: shared constants for the serial link back-channel and self test
// Assumes: 8-bit register map on the local management bus
// Notes:   all offsets, fields and reset values
package slbc_pkg;
  // register offsets
  localparam logic [7:0] ADDR_BUS_DEV     = 8'h00;
  localparam logic [7:0] ADDR_RST_CTL     = 8'h01;
  localparam logic [7:0] ADDR_DES_STS     = 8'h04;
  localparam logic [7:0] ADDR_PORT_SEL    = 8'h4C;
  localparam logic [7:0] ADDR_SER_GEN_STS = 8'h52; // far serializer map
  localparam logic [7:0] ADDR_ST_ERR_CNT  = 8'h57;
  localparam logic [7:0] ADDR_BC_CFG      = 8'h58;
  localparam logic [7:0] ADDR_ALIAS       = 8'h5C;
  localparam logic [7:0] ADDR_ST_CFG      = 8'hB3;
  localparam logic [7:0] ADDR_PORT_DBG    = 8'hD0;
  // backchannel_config fields
  localparam int BC_PASS_ALL   = 7;
  localparam int BC_PASS_MATCH = 6;
  localparam int BC_AUTO_ACK   = 5;
  localparam int BC_KEEP_ON    = 4;
  localparam int BC_CRC_EN     = 3;
  localparam logic [7:0] BC_CFG_RST = 8'h18;
  // back-channel rate codes
  localparam logic [2:0] RATE_2M5  = 3'h0;
  localparam logic [2:0] RATE_10M  = 3'h4;
  localparam logic [2:0] RATE_25M  = 3'h5;
  localparam logic [2:0] RATE_50M  = 3'h6;
  localparam logic [2:0] RATE_100M = 3'h7;
  localparam logic [2:0] RATE_RST  = 3'h0;
  // reset_control fields
  localparam int RST_KEEP_REGS = 0;
  localparam int RST_ALL       = 1;
  localparam int RST_ROM       = 2;
  // selftest_config and port debug fields
  localparam int ST_EN   = 0;
  localparam int ST_OSC  = 1;
  localparam int DBG_ONE = 0;
  localparam int DBG_CONT = 1;
  localparam int SEL_RD_PORT = 4;  // read-page select in port select
  // deserializer_status fields
  localparam int STS_CKSUM  = 7;
  localparam int STS_INIT   = 6;
  localparam int STS_REFCLK = 3;
  localparam int STS_PASS   = 2;
  localparam int STS_RCLK   = 1;
  localparam int STS_LOCK   = 0;
  // other reset values
  localparam logic [7:0] DEV_ADDR_RST  = 8'h30; // arbitrary value
  localparam logic [7:0] ALIAS_RST     = 8'h00;
  localparam logic [7:0] PORT_SEL_RST  = 8'h00;
  localparam logic [7:0] ST_CFG_RST    = 8'h00;
  // pattern checker
  localparam int PRBS_LEN   = 7;
  localparam int PRBS_TAP_A = 6;
  localparam int PRBS_TAP_B = 5;
endpackage : slbc_pkg

// ### slbc_chk_if.sv
// Purpose: carries one receive port's self-test checker signals
// Assumes: same clock on both ends
// Notes:   ctrl side drives stimulus, chk side returns the count
interface slbc_chk_if #(parameter int W = 8);
  logic         run;     // self test active
  logic         clear;   // zero counter and resync
  logic         bit_in;  // received pattern bit
  logic         bit_vld; // bit_in qualifier
  logic [W-1:0] count;   // saturating error count
  logic         synced;  // pattern detected
  modport ctrl (output run, clear, bit_in, bit_vld, input count, synced);
  modport chk  (input run, clear, bit_in, bit_vld, output count, synced);
endinterface : slbc_chk_if

// ### slbc_sync.sv
// Purpose: two-flop synchroniser for a group of pin levels
// Assumes: inputs are slow levels, not buses needing coherence
// Notes:   only the second stage is read outside
module slbc_sync #(
  parameter int W = 1
) (
  input  wire logic         i_mclk,  // system clock
  input  wire logic         i_rst_b, // async reset, low
  input  wire logic [W-1:0] i_d,     // asynchronous levels
  output      logic [W-1:0] o_q      // synchronised levels
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } slbc_sync_st_t;

  slbc_sync_st_t st;
  slbc_sync_st_t next_st;

  // first stage feeds only the second
  always_comb begin
    next_st.s1 = i_d;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_q = st.s2;
endmodule : slbc_sync

// ### slbc_prbs_chk.sv
// Purpose: pseudo-random pattern checker with saturating error count
// Assumes: 7-bit sequence, one bit per qualified cycle
// Notes:   self-synchronising; seeds from the first bits received
module slbc_prbs_chk
  import slbc_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic i_mclk,   // system clock
  input wire logic i_rst_b,  // async reset, low
  slbc_chk_if.chk  u_chk     // checker port
);
  typedef struct packed {
    logic [PRBS_LEN-1:0] hist;
    logic [2:0]          fill;
    logic                synced;
    logic [W-1:0]        count;
  } slbc_chk_st_t;

  slbc_chk_st_t st;
  slbc_chk_st_t next_st;
  logic         expect_bit;

  // expected bit from the feedback taps of the history
  assign expect_bit = st.hist[PRBS_TAP_A] ^ st.hist[PRBS_TAP_B];

  always_comb begin
    next_st = st;
    if (u_chk.clear || !u_chk.run) begin
      next_st.hist   = '0;
      next_st.fill   = '0;
      next_st.synced = 1'b0;
      if (u_chk.clear) begin
        next_st.count = '0;
      end
    end else if (u_chk.bit_vld) begin
      next_st.hist = {st.hist[PRBS_LEN-2:0], u_chk.bit_in};
      if (!st.synced) begin
        // pattern detected once the history is full
        next_st.fill = st.fill + 3'h1;
        if (st.fill == 3'(PRBS_LEN - 1)) begin
          next_st.synced = 1'b1;
        end
      end else if (u_chk.bit_in != expect_bit) begin
        // saturate so long tests never wrap back to a low count [R23]
        if (st.count != '1) begin
          next_st.count = st.count + 1'b1; // [R12]
        end
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign u_chk.count  = st.count;
  assign u_chk.synced = st.synced;
endmodule : slbc_prbs_chk

// ### slbc_top_properties.sv
// Purpose: concurrent checks on the block's ports
// Assumes: register port follows its contract
// Notes:   bound to slbc_top, sees its ports only
module slbc_top_properties
  import slbc_pkg::*;
#(
  parameter int NP = 2  // receive ports
) (
  input wire logic          i_mclk,          // clock
  input wire logic          i_rst_b,         // reset, low
  input wire logic          i_reg_wr,        // write strobe
  input wire logic [7:0]    i_reg_addr,      // offset
  input wire logic [7:0]    i_reg_wdata,     // write data
  input wire logic          i_reg_from_link, // remote write
  input wire logic          i_pll_locked,    // pll pin
  input wire logic          i_rx_valid,      // data valid pin
  input wire logic          i_bus_txn,       // bus transaction
  input wire logic          i_bus_wr,        // transaction is write
  input wire logic          i_addr_match,    // decode hit
  input wire logic          o_forward,       // pass on
  input wire logic          o_write_ack,     // local ack
  input wire logic          o_bc_enable,     // back channel on
  input wire logic [2:0]    o_bc_rate,       // rate code
  input wire logic          o_bc_crc_en,     // crc generator
  input wire logic          o_selftest_req,  // self test request
  input wire logic          o_soft_reset,    // logic reset pulse
  input wire logic          o_rom_reload,    // reload pulse
  input wire logic [NP-1:0] o_err_inject,    // error force
  input wire logic          o_lock           // lock status
);
  logic [7:0] cfg;
  logic       cfg_wr;
  assign cfg_wr = i_reg_wr && i_reg_addr == ADDR_BC_CFG;
  // shadow config; a remote write cannot touch the keep-on bit
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg <= BC_CFG_RST;
    end else if (i_reg_wr && i_reg_addr == ADDR_RST_CTL &&
                 i_reg_wdata[RST_ALL]) begin
      cfg <= BC_CFG_RST; // full reset restores defaults
    end else if (cfg_wr) begin
      cfg <= {i_reg_wdata[7:5], i_reg_from_link ? cfg[4] : i_reg_wdata[4],
              i_reg_wdata[3:0]};
    end
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  sequence s_pulse(sig);
    sig ##1 !sig;
  endsequence
  sequence s_rst_wr(int b);
    i_reg_wr && i_reg_addr == ADDR_RST_CTL && i_reg_wdata[b];
  endsequence
  pass_all_a: assert property (i_bus_txn && cfg[BC_PASS_ALL] |-> o_forward)
    else $error("forward missing with pass-all");
  pass_match_a: assert property (i_bus_txn && cfg[BC_PASS_MATCH] &&
    i_addr_match |-> o_forward) else $error("matched forward missing");
  pass_off_a: assert property (o_forward |-> i_bus_txn &&
    (cfg[7] || cfg[6] && i_addr_match)) else $error("forward without cause");
  auto_ack_a: assert property (i_bus_txn && i_bus_wr && cfg[BC_AUTO_ACK]
    |-> o_write_ack) else $error("auto ack missing");
  bc_on_a: assert property (o_bc_enable == (cfg[4] || cfg[7] || cfg[6]))
    else $error("back channel enable wrong");
  crc_gen_a: assert property (o_bc_crc_en == cfg[BC_CRC_EN])
    else $error("crc enable wrong");
  rate_set_a: assert property (cfg_wr && !(i_reg_wdata[2:0] inside {1, 2, 3})
    |=> o_bc_rate == $past(i_reg_wdata[2:0])) else $error("rate not taken");
  rate_keep_a: assert property (cfg_wr && i_reg_wdata[2:0] inside {1, 2, 3}
    |=> $stable(o_bc_rate)) else $error("reserved rate applied");
  st_req_a: assert property (i_reg_wr && i_reg_addr == ADDR_ST_CFG
    |=> o_selftest_req == $past(i_reg_wdata[ST_EN])) else $error("st req");
  soft_pulse_a: assert property (s_rst_wr(RST_KEEP_REGS)
    |=> s_pulse(o_soft_reset)) else $error("soft reset pulse wrong");
  rom_pulse_a: assert property (s_rst_wr(RST_ROM)
    |=> s_pulse(o_rom_reload)) else $error("rom reload pulse wrong");
  inject_one_a: assert property (i_reg_wr && i_reg_addr == ADDR_PORT_DBG &&
    i_reg_wdata == 8'h01 && o_err_inject == '0 |=> ##1 o_err_inject == '0)
    else $error("single inject not self clearing");
  lock_on_a: assert property ((i_pll_locked && i_rx_valid) [*3] |-> o_lock)
    else $error("lock missing");
  lock_off_a: assert property (o_lock |-> $past(i_pll_locked, 2) &&
    $past(i_rx_valid, 2)) else $error("lock without cause");
endmodule : slbc_top_properties

bind slbc_top slbc_top_properties #(.NP(NP)) u_props (.*);

// ### slbc_far_ser.sv
// Purpose: far serializer model
// Assumes: one pattern bit per clock while requested
// Notes:   idle data line toggles so a stale value is never trusted
module slbc_far_ser #(
  parameter int NP = 2  // receive ports
) (
  input  wire logic          i_mclk,    // clock
  input  wire logic          i_rst_b,   // reset, low
  input  wire logic          i_run,     // self test request
  input  wire logic [NP-1:0] i_invert,  // corrupt this port
  input  wire logic [NP-1:0] i_bc_err,  // forced back-channel error
  output      logic [NP-1:0] o_bit,     // pattern bit
  output      logic [NP-1:0] o_vld,     // bit qualifier
  output      logic [7:0]    o_crc_fail, // failed frames seen
  output      logic [7:0]    o_gen_sts   // status byte
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [6:0] lfsr;
  logic       nb;
  assign nb = lfsr[6] ^ lfsr[5];
  // locked and linked; error bit once a frame failed
  assign o_gen_sts = {5'h10, 1'b1, |o_crc_fail, 1'b1};
  // continuous pattern at full rate while requested
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lfsr <= 7'h01;
      o_bit <= '0;
      o_vld <= '0;
      o_crc_fail <= 8'h00;
    end else begin
      o_crc_fail <= o_crc_fail + {7'h00, |i_bc_err};
      o_vld <= {NP{i_run}};
      o_bit <= i_run ? {NP{nb}} ^ i_invert : ~o_bit;
      if (i_run) begin
        lfsr <= {lfsr[5:0], nb};
      end
    end
  end
endmodule : slbc_far_ser

// ### slbc_top_test.sv
// Purpose: self-checking bench for the back-channel and self-test block
// Assumes: far serializer model drives the pattern inputs
// Notes:   read data checked against a queue of notes
module slbc_top_test
  import slbc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       i_mclk, i_rst_b, i_reg_wr, i_reg_rd, i_reg_from_link;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, crc_fail, gen_sts;
  logic       i_power_down_release, i_pll_locked, i_rx_valid;
  logic       i_refclk_valid, i_bus_txn, i_bus_wr, i_addr_match;
  logic       i_remote_ack, o_forward, o_write_ack, o_bc_enable;
  logic       o_bc_crc_en, o_selftest_req, o_selftest_osc, o_soft_reset;
  logic       o_rom_reload, o_lock, rd_q;
  logic [2:0] i_strap_rate, o_bc_rate;
  logic [1:0] o_err_inject, i_rx_bit, i_rx_bit_valid, invert;
  logic [7:0] exp_q[$];
  int         fail_count, check_count, seed;

  slbc_top #(.NP(2), .CW(8)) dut (.i_mclk, .i_rst_b, .i_reg_wr, .i_reg_rd,
    .i_reg_addr, .i_reg_wdata, .i_reg_from_link, .o_reg_rdata,
    .i_power_down_release, .i_strap_rate, .i_pll_locked, .i_rx_valid,
    .i_refclk_valid, .i_bus_txn, .i_bus_wr, .i_addr_match, .i_remote_ack,
    .o_forward, .o_write_ack, .o_bc_enable, .o_bc_rate, .o_bc_crc_en,
    .o_selftest_req, .o_selftest_osc, .o_soft_reset, .o_rom_reload,
    .o_err_inject, .i_rx_bit, .i_rx_bit_valid, .o_lock);
  slbc_far_ser #(.NP(2)) u_far (.i_mclk, .i_rst_b, .i_run(o_selftest_req),
    .i_invert(invert), .i_bc_err(o_err_inject), .o_bit(i_rx_bit),
    .o_vld(i_rx_bit_valid), .o_crc_fail(crc_fail), .o_gen_sts(gen_sts));

  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
                     input string nm);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic end_sim();
    if (fail_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  // strobes span one rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic l);
    @(negedge i_mclk);
    i_reg_wr = 1'b1;
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_from_link = l;
    @(negedge i_mclk);
    i_reg_wr = 1'b0;
    i_reg_from_link = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge i_mclk);
    i_reg_rd = 1'b1;
    i_reg_addr = a;
    exp_q.push_back(e);
    @(negedge i_mclk);
    i_reg_rd = 1'b0;
  endtask : rd

  // lock lags pins by the synchroniser
  task automatic wait_lock(input logic v);
    int n;
    n = 0;
    while (o_lock !== v && n < 8) begin
      @(negedge i_mclk);
      n++;
    end
    chk(o_lock, v, "lock");
  endtask : wait_lock

  // data lands a cycle after the strobe
  always @(posedge i_mclk) rd_q <= i_reg_rd;
  always @(negedge i_mclk) begin
    if (rd_q) begin
      chk(o_reg_rdata, exp_q.pop_front(), "rdata");
    end
  end

  initial begin
    repeat (20000) @(posedge i_mclk);
    fail_count++;
    end_sim();
  end

  initial begin
    logic [7:0] cfg;
    logic [2:0] rate;
    seed = 42954;
    {i_rst_b, i_reg_wr, i_reg_rd, i_reg_from_link} = '0;
    {i_power_down_release, i_pll_locked, i_rx_valid, i_refclk_valid} = '0;
    {i_bus_txn, i_bus_wr, i_addr_match, i_remote_ack, invert} = '0;
    {i_reg_addr, i_reg_wdata} = '0;
    i_strap_rate = RATE_25M;
    repeat (6) @(negedge i_mclk);
    i_rst_b = 1'b1;
    // reset values and unmapped reads
    rd(ADDR_BC_CFG, BC_CFG_RST);
    rd(ADDR_BUS_DEV, DEV_ADDR_RST);
    rd(ADDR_ALIAS, ALIAS_RST);
    rd(ADDR_ST_CFG, ST_CFG_RST);
    rd(ADDR_SER_GEN_STS, 8'h00);
    rd(8'h99, 8'h00);
    // strap rate taken when power-down is released
    i_power_down_release = 1'b1;
    repeat (4) @(negedge i_mclk);
    chk(o_bc_rate, RATE_25M, "strap rate");
    rd(ADDR_BC_CFG, BC_CFG_RST | 8'h05);
    // all codes, reserved after valid; auto-ack on while retuning
    for (int c = 7; c >= 0; c--) begin
      wr(ADDR_BC_CFG, 8'h38 | c[7:0], 1'b0);
      if (!(c inside {1, 2, 3})) rate = c[2:0];
      chk(o_bc_rate, rate, "rate");
      rd(ADDR_BC_CFG, 8'h38 | c[7:0]);
    end
    // random config and traffic, lock still low
    for (int n = 0; n < 24; n++) begin
      cfg = 8'($random(seed));
      cfg[2:0] = RATE_50M;
      wr(ADDR_BC_CFG, cfg, 1'b0);
      {i_bus_txn, i_bus_wr, i_addr_match, i_remote_ack} = 4'($random(seed));
      #1;
      chk(o_forward, i_bus_txn & (cfg[7] | cfg[6] & i_addr_match), "fwd");
      chk(o_write_ack, i_bus_txn & i_bus_wr & cfg[5], "ack");
      chk(o_bc_enable, cfg[4] | cfg[7] | cfg[6], "bc_enable");
      chk(o_bc_crc_en, cfg[3], "crc_en");
    end
    // keep-on bit ignores remote writes
    wr(ADDR_BC_CFG, 8'h1E, 1'b0);
    wr(ADDR_BC_CFG, 8'h06, 1'b1);
    rd(ADDR_BC_CFG, 8'h16);
    wr(ADDR_BC_CFG, 8'h06, 1'b0);
    chk(o_bc_enable, 1'b0, "bc_enable");
    wr(ADDR_BC_CFG, BC_CFG_RST, 1'b0);
    // lock status and status byte
    {i_pll_locked, i_rx_valid, i_refclk_valid} = 3'b111;
    wait_lock(1'b1);
    rd(ADDR_DES_STS, 8'hCF);
    i_pll_locked = 1'b0;
    wait_lock(1'b0);
    rd(ADDR_DES_STS, 8'hC8);
    i_pll_locked = 1'b1;
    // single inject, then continuous on port 1
    wr(ADDR_PORT_SEL, 8'h03, 1'b0);
    wr(ADDR_PORT_DBG, 8'h01, 1'b0);
    chk(o_err_inject, 2'b11, "inject");
    @(negedge i_mclk);
    chk(o_err_inject, 2'b00, "inject");
    chk(crc_fail, 8'h01, "far crc fails");
    chk(gen_sts, 8'h87, "far status");
    wr(ADDR_PORT_SEL, 8'h02, 1'b0);
    wr(ADDR_PORT_DBG, 8'h02, 1'b0);
    repeat (3) @(negedge i_mclk);
    chk(o_err_inject, 2'b10, "inject");
    wr(ADDR_PORT_DBG, 8'h00, 1'b0);
    chk(o_err_inject, 2'b00, "inject");
    // port 0 clean, port 1 saturates
    invert = 2'b10;
    wr(ADDR_ST_CFG, 8'h03, 1'b0);
    chk(o_selftest_req, 1'b1, "st_req");
    chk(o_selftest_osc, 1'b1, "st_osc");
    repeat (320) @(negedge i_mclk);
    wr(ADDR_ST_CFG, 8'h00, 1'b0);
    chk(o_selftest_req, 1'b0, "st_req");
    wr(ADDR_PORT_SEL, 8'h00, 1'b0);
    rd(ADDR_ST_ERR_CNT, 8'h00);
    wr(ADDR_PORT_SEL, 8'h10, 1'b0);
    rd(ADDR_ST_ERR_CNT, 8'hFF);
    // logic, full and reload resets
    wr(ADDR_RST_CTL, 8'h01, 1'b0);
    chk(o_soft_reset, 1'b1, "soft_reset");
    rd(ADDR_ST_ERR_CNT, 8'h00);
    wr(ADDR_ALIAS, 8'hA5, 1'b0);
    rd(ADDR_ALIAS, 8'hA5);
    wr(ADDR_RST_CTL, 8'h02, 1'b0);
    @(negedge i_mclk);
    rd(ADDR_ALIAS, ALIAS_RST);
    rd(ADDR_PORT_SEL, PORT_SEL_RST);
    wr(ADDR_RST_CTL, 8'h04, 1'b0);
    chk(o_rom_reload, 1'b1, "rom_reload");
    repeat (3) @(negedge i_mclk);
    end_sim();
  end
endmodule : slbc_top_test
